/* hdl/coef_bank_pkg.sv */
// Purpose: shared constants for coefficient bank selection control
// Assumes: 25 MHz control clock, control register reached through the serial control port decoder
// Notes: bank codes are 0 = bank 1, 1 = bank 2, 2 = bank 3
package coef_bank_pkg;
    localparam logic [7:0] BANK_CTRL_OFFSET = 8'h40;
    localparam logic [31:0] BANK_CTRL_RESET = 32'h0000_FF00;
    // field positions of coefficient_bank_control
    localparam int SEL_LSB = 16;
    localparam int SEL_W = 3;
    localparam int BANK1_RATES_LSB = 8;
    localparam int BANK2_RATES_LSB = 0;
    localparam int RATES_W = 8;
    localparam logic [31:0] BANK_CTRL_USED_MASK = 32'h0007_FFFF;
    // bank-selection field values
    localparam logic [2:0] SEL_MANUAL_B1 = 3'h0;
    localparam logic [2:0] SEL_MANUAL_B2 = 3'h1;
    localparam logic [2:0] SEL_MANUAL_B3 = 3'h2;
    localparam logic [2:0] SEL_AUTO = 3'h3;
    localparam logic [2:0] SEL_SET_B1 = 3'h4;
    localparam logic [2:0] SEL_SET_B2 = 3'h5;
    localparam logic [2:0] SEL_SET_B3 = 3'h6;
    localparam logic [1:0] BANK1 = 2'h0;
    localparam logic [1:0] BANK2 = 2'h1;
    localparam logic [1:0] BANK3 = 2'h2;
    // bank-related coefficient subaddresses
    localparam logic [7:0] BIQUAD_FIRST = 8'h51;
    localparam logic [7:0] BIQUAD_LAST = 8'h88;
    localparam logic [7:0] LOUDNESS_BIQUAD = 8'h95;
    localparam logic [7:0] DRC1_ENERGY = 8'h98;
    localparam logic [7:0] DRC1_TIMING = 8'h9C;
    localparam logic [7:0] DRC2_ENERGY = 8'h9D;
    localparam logic [7:0] DRC2_TIMING = 8'hA1;
    localparam logic [7:0] BASS_SET = 8'hDA;
    localparam logic [7:0] TREBLE_SET = 8'hDC;
    // quiet period after a bank switch starts
    localparam int CLK_HZ = 25_000_000;
    localparam int QUIET_MS = 186;
    localparam int QUIET_CYCLES = QUIET_MS * (CLK_HZ / 1000);
    localparam int QUIET_CNT_W = 23;
endpackage

/* hdl/bank_rate_select.sv */
// Purpose: picks the bank associated with a detected data rate
// Assumes: rate code 0..7 indexes the rate mask bits from the top bit down
// Notes: purely combinational
`timescale 1ns/1ns
module bank_rate_select #(
    parameter int RATES_W = coef_bank_pkg::RATES_W
) (
    input wire logic [2:0] rate_code,
    input wire logic [RATES_W-1:0] bank1_rates,
    input wire logic [RATES_W-1:0] bank2_rates,
    output logic [1:0] rate_bank
);
    wire [2:0] bit_idx = 3'(RATES_W - 1) - rate_code;
    wire in_bank1 = bank1_rates[bit_idx];
    wire in_bank2 = bank2_rates[bit_idx];

    // bank 1 checked first, then bank 2, anything else lands in bank 3
    assign rate_bank = in_bank1 ? coef_bank_pkg::BANK1 :
                       in_bank2 ? coef_bank_pkg::BANK2 : coef_bank_pkg::BANK3;
endmodule

/* hdl/coef_bank_ctrl.sv */
// Purpose: bank control register, manual/automatic bank switching and bank-set mode
// Assumes: control port decoder delivers one-cycle write strobes with subaddress and data
// Notes: mute/unmute ramps are run outside and acknowledged by done pulses
`timescale 1ns/1ns

// Behaviour
// - writing 4, 5 or 6 to the bank-selection field enters bank-set mode aimed at bank 1, 2 or 3.
// - in bank-set mode tone, EQ, dynamics and loudness coefficient writes are accepted for the aimed bank.
// - while bank-set mode is active no new manual or automatic bank switch starts; one already under way still completes.
// - entering bank-set mode leaves the active bank used for audio untouched.
// - entered from automatic mode, a clock error or rate change cannot disturb a coefficient write.
// - writing 3 to the bank-selection field at offset 0x40 selects switching by detected rate.
// - in automatic mode a new sample rate activates its associated bank without host action.
// - in automatic mode a rate tied to neither bank 1 nor bank 2 selects bank 3.
// - field values 0, 1 and 2 manually select bank 1, 2 and 3.
// - a detected rate is checked against bank 1 first, then bank 2, otherwise bank 3 is used.
// - after reset the control is manual with bank 1 active.
// - a switch made while audio streams is wrapped in a mute ramp before and an unmute ramp after.
module coef_bank_ctrl #(
    parameter int QUIET_CYCLES = coef_bank_pkg::QUIET_CYCLES,
    parameter int COEF_W = 32
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rd_data_q,
    input wire logic coef_wr_en,
    input wire logic [COEF_W-1:0] coef_wr_data,
    input wire logic [2:0] rate_code,
    input wire logic rate_change,
    input wire logic audio_streaming,
    input wire logic mute_done,
    input wire logic unmute_done,
    output logic [1:0] active_bank_q,
    output logic bank_set_mode_q,
    output logic auto_mode_q,
    output logic mute_req_q,
    output logic unmute_req_q,
    output logic switch_busy_q,
    output logic coef_out_en_q,
    output logic [1:0] coef_out_bank_q,
    output logic [7:0] coef_out_addr_q,
    output logic [COEF_W-1:0] coef_out_data_q
);
    typedef enum logic [2:0] {ST_IDLE, ST_MUTE, ST_SWITCH, ST_UNMUTE, ST_QUIET} sw_state_e;

    function automatic logic is_bank_coef(input logic [7:0] a);
        is_bank_coef = (a >= coef_bank_pkg::BIQUAD_FIRST && a <= coef_bank_pkg::BIQUAD_LAST) ||
                       a == coef_bank_pkg::LOUDNESS_BIQUAD || a == coef_bank_pkg::DRC1_ENERGY ||
                       a == coef_bank_pkg::DRC1_TIMING || a == coef_bank_pkg::DRC2_ENERGY ||
                       a == coef_bank_pkg::DRC2_TIMING || a == coef_bank_pkg::BASS_SET ||
                       a == coef_bank_pkg::TREBLE_SET;
    endfunction

    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    sw_state_e state_q;
    sw_state_e state_d;
    logic [1:0] target_q;
    logic [1:0] target_d;
    logic rate_pend_q;
    logic rate_pend_d;
    logic [coef_bank_pkg::QUIET_CNT_W-1:0] quiet_cnt_q;
    logic [coef_bank_pkg::QUIET_CNT_W-1:0] quiet_cnt_d;
    logic [1:0] active_bank_d;
    logic [1:0] rate_bank;

    ////////////////////////////////////////////////////////////////////////////////
    // register decode

    wire ctrl_hit = reg_addr == coef_bank_pkg::BANK_CTRL_OFFSET;
    wire ctrl_wr = reg_wr_en && ctrl_hit;
    wire [2:0] sel = ctrl_q[coef_bank_pkg::SEL_LSB +: coef_bank_pkg::SEL_W];
    wire [2:0] wsel = reg_wdata[coef_bank_pkg::SEL_LSB +: coef_bank_pkg::SEL_W];
    wire [7:0] bank1_rates = ctrl_q[coef_bank_pkg::BANK1_RATES_LSB +: coef_bank_pkg::RATES_W];
    wire [7:0] bank2_rates = ctrl_q[coef_bank_pkg::BANK2_RATES_LSB +: coef_bank_pkg::RATES_W];
    wire sel_manual = sel <= coef_bank_pkg::SEL_MANUAL_B3;
    wire sel_auto = sel == coef_bank_pkg::SEL_AUTO;
    wire sel_set = sel >= coef_bank_pkg::SEL_SET_B1 && sel <= coef_bank_pkg::SEL_SET_B3;
    wire [1:0] manual_bank = sel[1:0];
    wire [1:0] set_bank = 2'(sel - coef_bank_pkg::SEL_SET_B1);
    wire wsel_auto = wsel == coef_bank_pkg::SEL_AUTO;

    // unused and reserved bits are not stored and read back as zero
    assign ctrl_d = ctrl_wr ? (reg_wdata & coef_bank_pkg::BANK_CTRL_USED_MASK) : ctrl_q;

    bank_rate_select #(
        .RATES_W(coef_bank_pkg::RATES_W)
    ) u_rate_sel (
        .rate_code(rate_code),
        .bank1_rates(bank1_rates),
        .bank2_rates(bank2_rates),
        .rate_bank(rate_bank)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // switch request

    // a rate change seen during bank-set mode is held and acted on once automatic mode returns
    assign rate_pend_d = rate_change || (ctrl_wr && wsel_auto && !sel_auto) ||
                         (rate_pend_q && !(state_q == ST_IDLE && sel_auto));

    wire want_manual = sel_manual && manual_bank != active_bank_q;
    wire want_auto = sel_auto && rate_pend_q && rate_bank != active_bank_q;
    // bank-set mode blocks every new switch; a switch already under way still completes and sets the active bank
    wire start_switch = state_q == ST_IDLE && !sel_set && (want_manual || want_auto);
    wire [1:0] want_bank = sel_auto ? rate_bank : manual_bank;
    wire quiet_last = quiet_cnt_q == coef_bank_pkg::QUIET_CNT_W'(QUIET_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // switch sequencer

    always_comb begin
        state_d = state_q;
        target_d = target_q;
        active_bank_d = active_bank_q;
        quiet_cnt_d = quiet_cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (start_switch) begin
                    target_d = want_bank;
                    quiet_cnt_d = '0;
                    state_d = audio_streaming ? ST_MUTE : ST_SWITCH;
                end
            end
            ST_MUTE: begin
                if (mute_done) begin
                    state_d = ST_SWITCH;
                end
            end
            ST_SWITCH: begin
                active_bank_d = target_q;
                state_d = audio_streaming ? ST_UNMUTE : ST_QUIET;
            end
            ST_UNMUTE: begin
                if (unmute_done) begin
                    state_d = ST_QUIET;
                end
            end
            ST_QUIET: begin
                if (quiet_last) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // the quiet window counts from the start of the switch
        if (state_q != ST_IDLE && !quiet_last) begin
            quiet_cnt_d = quiet_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // coefficient write steering

    wire coef_bank_wr = coef_wr_en && is_bank_coef(reg_addr);
    // bank-set writes land in the aimed bank, otherwise in the bank in use
    wire [1:0] coef_bank = sel_set ? set_bank : active_bank_q;

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= coef_bank_pkg::BANK_CTRL_RESET;
            state_q <= ST_IDLE;
            target_q <= coef_bank_pkg::BANK1;
            active_bank_q <= coef_bank_pkg::BANK1;
            rate_pend_q <= 1'b0;
            quiet_cnt_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            target_q <= target_d;
            active_bank_q <= active_bank_d;
            rate_pend_q <= rate_pend_d;
            quiet_cnt_q <= quiet_cnt_d;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_data_q <= 32'h0000_0000;
            bank_set_mode_q <= 1'b0;
            auto_mode_q <= 1'b0;
            mute_req_q <= 1'b0;
            unmute_req_q <= 1'b0;
            switch_busy_q <= 1'b0;
        end else begin
            reg_rd_data_q <= ctrl_hit ? ctrl_q : 32'h0000_0000;
            bank_set_mode_q <= sel_set;
            auto_mode_q <= sel_auto;
            mute_req_q <= state_d == ST_MUTE || state_d == ST_SWITCH && state_q == ST_MUTE;
            unmute_req_q <= state_d == ST_UNMUTE;
            switch_busy_q <= state_d != ST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            coef_out_en_q <= 1'b0;
            coef_out_bank_q <= coef_bank_pkg::BANK1;
            coef_out_addr_q <= 8'h00;
            coef_out_data_q <= '0;
        end else begin
            coef_out_en_q <= coef_bank_wr;
            coef_out_bank_q <= coef_bank;
            coef_out_addr_q <= reg_addr;
            coef_out_data_q <= coef_wr_data;
        end
    end
endmodule

/* tb/coef_bank_sva.sv */
// Purpose: timing checks on the coefficient bank controller ports
// Assumes: one clock domain, async active-low reset
// Notes: tgt_q keeps the low select bits of the last control write
`timescale 1ns/1ns
module coef_bank_sva (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic coef_wr_en,
    input wire logic audio_streaming,
    input wire logic mute_done,
    input wire logic [1:0] active_bank_q,
    input wire logic bank_set_mode_q,
    input wire logic auto_mode_q,
    input wire logic mute_req_q,
    input wire logic unmute_req_q,
    input wire logic switch_busy_q,
    input wire logic coef_out_en_q,
    input wire logic [1:0] coef_out_bank_q
);
    logic [1:0] tgt_q;
    wire wr40 = reg_wr_en && reg_addr == coef_bank_pkg::BANK_CTRL_OFFSET;
    wire [2:0] fld = reg_wdata[18:16];
    wire coef_hit = coef_wr_en && reg_addr >= coef_bank_pkg::BIQUAD_FIRST && reg_addr <= coef_bank_pkg::BIQUAD_LAST;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tgt_q <= 2'h0;
        end else if (wr40) begin
            tgt_q <= fld[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    set_entry_a: assert property (wr40 && fld inside {3'h4, 3'h5, 3'h6} |=> ##1 bank_set_mode_q)
        else $error("bank-set entry missed");
    set_hold_a: assert property (bank_set_mode_q && !$past(switch_busy_q)
        |-> !switch_busy_q && $stable(active_bank_q))
        else $error("bank changed in bank-set mode");
    coef_fwd_a: assert property (coef_hit |=> coef_out_en_q)
        else $error("coefficient write not forwarded");
    no_coef_a: assert property (coef_wr_en && reg_addr == 8'h50 |=> !coef_out_en_q)
        else $error("unrelated address forwarded");
    set_target_a: assert property (coef_out_en_q && bank_set_mode_q |-> coef_out_bank_q == tgt_q)
        else $error("coefficient write went to wrong bank");
    manual_sel_a: assert property (wr40 && fld < 3'h3 && !switch_busy_q && !audio_streaming && !bank_set_mode_q
        |-> ##[2:5] active_bank_q == tgt_q)
        else $error("manual bank not applied");
    auto_mode_a: assert property (wr40 && fld == 3'h3 |=> ##1 auto_mode_q)
        else $error("automatic mode not entered");
    reset_state_a: assert property ($rose(reset_n) |-> active_bank_q == 2'h0 && !bank_set_mode_q && !auto_mode_q)
        else $error("state after reset wrong");
    mute_first_a: assert property ($rose(switch_busy_q) && $past(audio_streaming) |-> mute_req_q)
        else $error("switch without mute");
    unmute_after_a: assert property (mute_req_q && mute_done
        |=> mute_req_q ##1 !mute_req_q && (unmute_req_q || !$past(audio_streaming)))
        else $error("no unmute after switch");
    cover property (wr40 && fld == 3'h5);
    cover property (mute_req_q && mute_done);
    cover property (auto_mode_q && $rose(switch_busy_q));
endmodule
bind coef_bank_ctrl coef_bank_sva i_coef_bank_sva (.mclk, .reset_n, .reg_wr_en, .reg_addr, .reg_wdata, .coef_wr_en,
    .audio_streaming, .mute_done, .active_bank_q, .bank_set_mode_q, .auto_mode_q, .mute_req_q, .unmute_req_q,
    .switch_busy_q, .coef_out_en_q, .coef_out_bank_q);

/* tb/coef_host.sv */
// Purpose: host processor model on the control port
// Assumes: one strobe per word, signals changed at the falling edge
// Notes: released data shows the inverse of the last word
`timescale 1ns/1ns
module coef_host (
    input wire logic mclk,
    input wire logic switch_busy_q,
    input wire logic [31:0] reg_rd_data_q,
    output logic reg_wr_en,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic coef_wr_en,
    output logic [31:0] coef_wr_data
);
    initial begin
        {reg_wr_en, coef_wr_en, reg_addr, reg_wdata, coef_wr_data} = '0;
    end
    ////////////////////////////////////////////////////////////////
    task wr(input logic coef, input logic [7:0] a, input logic [31:0] d);
        int i;
        for (i = 0; i < 400 && switch_busy_q !== 1'b0; i++) @(negedge mclk);
        if (i == 400) begin
            coef_bank_ctrl_tb_top.chk("host busy wait", 32'h0, 32'h1);
            coef_bank_ctrl_tb_top.give_verdict();
        end
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        coef_wr_data = d;
        reg_wr_en = !coef;
        coef_wr_en = coef;
        @(negedge mclk);
        {reg_wr_en, coef_wr_en, reg_addr} = '0;
        reg_wdata = ~d;
        coef_wr_data = ~d;
    endtask
    task rd(output logic [31:0] d);
        @(negedge mclk);
        reg_addr = 8'h40;
        @(negedge mclk);
        d = reg_rd_data_q;
        reg_addr = 8'h00;
    endtask
endmodule

/* tb/coef_bank_ctrl_tb_top.sv */
// Purpose: self-checking bench for the coefficient bank controller
// Assumes: quiet window shortened to 20 cycles, ramps acknowledged at once
// Notes: rate code 0 is bit 7 of each rate byte
`timescale 1ns/1ns
module coef_bank_ctrl_tb_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] rate_code = 3'h5;
    logic rate_change = 1'b0;
    logic audio_streaming = 1'b0;
    logic mute_done = 1'b0;
    logic unmute_done = 1'b0;
    logic reg_wr_en, coef_wr_en, bank_set_mode_q, auto_mode_q, mute_req_q, unmute_req_q, switch_busy_q, coef_out_en_q;
    logic [7:0] reg_addr, coef_out_addr_q;
    logic [31:0] reg_wdata, coef_wr_data, reg_rd_data_q, coef_out_data_q;
    logic [1:0] active_bank_q, coef_out_bank_q;
    int n_fail = 0;
    int comparisons = 0;
    int n_mute = 0;
    always #20 mclk = ~mclk;
    always @(negedge mclk) begin
        mute_done <= mute_req_q && !mute_done;
        unmute_done <= unmute_req_q && !unmute_done;
        n_mute <= n_mute + int'(mute_req_q && !mute_done);
    end
    coef_bank_ctrl #(.QUIET_CYCLES(20)) i_coef_bank_ctrl (.mclk, .reset_n, .reg_wr_en, .reg_addr, .reg_wdata,
        .reg_rd_data_q, .coef_wr_en, .coef_wr_data, .rate_code, .rate_change, .audio_streaming, .mute_done,
        .unmute_done, .active_bank_q, .bank_set_mode_q, .auto_mode_q, .mute_req_q, .unmute_req_q, .switch_busy_q,
        .coef_out_en_q, .coef_out_bank_q, .coef_out_addr_q, .coef_out_data_q);
    coef_host i_coef_host (.mclk, .switch_busy_q, .reg_rd_data_q, .reg_wr_en, .reg_addr, .reg_wdata, .coef_wr_en,
        .coef_wr_data);
    ////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task give_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task wait_idle();
        int i;
        repeat (3) @(negedge mclk);
        for (i = 0; i < 300 && switch_busy_q !== 1'b0; i++) @(negedge mclk);
        if (i == 300) begin
            chk("busy timeout", 32'h0, 32'h1);
            give_verdict();
        end
    endtask
    task sw(input logic [31:0] w, input logic [1:0] exp, input string nm);
        if (w !== 32'h0) begin
            i_coef_host.wr(1'b0, 8'h40, w);
        end else begin
            rate_change = 1'b1;
            @(negedge mclk);
            rate_change = 1'b0;
        end
        wait_idle();
        chk(nm, exp, active_bank_q);
    endtask
    ////////////////////////////////////////////////////////////////
    task t_reset();
        logic [31:0] d;
        i_coef_host.rd(d);
        chk("ctrl reset", 32'h0000_FF00, d);
        chk("bank reset", 2'h0, active_bank_q);
        $display("t_reset done");
    endtask
    task t_set();
        int b;
        logic [7:0] a;
        for (b = 0; b < 3; b++) begin
            a = b == 0 ? 8'h51 : b == 1 ? 8'h88 : 8'hDC;
            i_coef_host.wr(1'b0, 8'h40, 32'h0004_8040 + (b << 16));
            i_coef_host.wr(1'b1, a, 32'hC0EF_0000 + b);
            chk("coef strobe", 1'b1, coef_out_en_q);
            chk("coef addr", a, coef_out_addr_q);
            chk("set flag", 1'b1, bank_set_mode_q);
            chk("coef bank", b[1:0], coef_out_bank_q);
            chk("coef data", 32'hC0EF_0000 + b, coef_out_data_q);
            chk("bank kept", 2'h0, active_bank_q);
        end
        i_coef_host.wr(1'b1, 8'h50, 32'h1234_5678);
        chk("unrelated strobe", 1'b0, coef_out_en_q);
        sw(32'h0000_8040, 2'h0, "set exit");
        chk("set flag off", 1'b0, bank_set_mode_q);
        $display("t_set done");
    endtask
    task t_manual();
        audio_streaming = 1'b1;
        sw(32'h0001_8040, 2'h1, "manual b2");
        chk("mute count", 32'h1, n_mute);
        audio_streaming = 1'b0;
        $display("t_manual done");
    endtask
    task t_auto();
        sw(32'h0000_8040, 2'h0, "manual b1");
        sw(32'h0003_8040, 2'h2, "auto other");
        chk("auto flag", 1'b1, auto_mode_q);
        rate_code = 3'h0;
        sw(32'h0, 2'h0, "auto b1");
        i_coef_host.wr(1'b0, 8'h40, 32'h0005_8040);
        rate_code = 3'h1;
        sw(32'h0, 2'h0, "set hold");
        rate_change = 1'b1;
        i_coef_host.wr(1'b1, 8'h95, 32'h0000_5A5A);
        rate_change = 1'b0;
        chk("set coef strobe", 1'b1, coef_out_en_q);
        chk("set coef bank", 2'h1, coef_out_bank_q);
        chk("set coef data", 32'h0000_5A5A, coef_out_data_q);
        chk("set hold bank", 2'h0, active_bank_q);
        sw(32'h0003_8040, 2'h1, "auto b2");
        $display("t_auto done");
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        t_reset();
        t_set();
        t_manual();
        t_auto();
        give_verdict();
    end
endmodule
